// ===== common/bbr_pkg.sv
// Constants, types and decode helpers shared by the bit-band remapper.
// Assumes a 32-bit little-endian data bus with byte lanes set by address.
package bbr_pkg;

    // Alias windows and the bit-band areas they fold onto.
    localparam logic [31:0] SRAM_ALIAS_LO  = 32'h2200_0000;
    localparam logic [31:0] SRAM_ALIAS_HI  = 32'h222F_FFFF;
    localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
    localparam logic [31:0] PERI_ALIAS_LO  = 32'h4200_0000;
    localparam logic [31:0] PERI_ALIAS_HI  = 32'h43FF_FFFF;
    localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;

    // Alias offset fields: byte offset (1 MB span) and bit number.
    localparam int OFF_W        = 25;
    localparam int BYTE_OFF_LSB = 5;
    localparam int BYTE_OFF_W   = 20;
    localparam int BIT_NUM_LSB  = 2;
    localparam int BIT_NUM_W    = 3;

    // Access sizes.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    // Reset value of the read data register.
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Reserved address ranges that answer with a fault.
    localparam int RSV_N = 6;
    localparam logic [RSV_N-1:0][31:0] RSV_LO = {
        32'hE010_0000, 32'h4400_0000, 32'h4010_0000,
        32'h2230_0000, 32'h2002_0000, 32'h0004_0000};
    localparam logic [RSV_N-1:0][31:0] RSV_HI = {
        32'hFFFF_FFFF, 32'h5FFF_FFFF, 32'h41FF_FFFF,
        32'h3FFF_FFFF, 32'h21FF_FFFF, 32'h00FF_FFFF};

    typedef enum logic [1:0] {
        BBR_PASS,
        BBR_ALIAS,
        BBR_FAULT
    } bbr_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PASS,
        ST_ARD,
        ST_RMW_RD,
        ST_RMW_WR
    } bbr_state_t;

    function automatic logic in_rng(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic is_reserved(input logic [31:0] a);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < RSV_N; i++) begin
            hit = hit | in_rng(a, RSV_LO[i], RSV_HI[i]);
        end
        return hit;
    endfunction

endpackage

// ===== rtl/bbr_decode.sv
// Address classifier: alias, pass-through or fault, plus bit translation.
// Purely combinational; fed directly from the unregistered request inputs of the top level.
`timescale 1ns/1ps
module bbr_decode
    import bbr_pkg::*;
(
    // Request attributes
    input  wire logic [31:0] addr,
    input  wire logic [1:0]  size,
    input  wire logic        fetch,
    // Classification and translated target
    output bbr_kind_t        kind,
    output logic [31:0]      tgt_addr,
    output logic [4:0]       bit_pos
);

    logic                  in_sram;
    logic                  in_peri;
    logic [31:0]           diff;
    logic [BYTE_OFF_W-1:0] byte_off;
    logic [BIT_NUM_W-1:0]  bit_num;
    logic [31:0]           band;

    assign in_sram  = in_rng(addr, SRAM_ALIAS_LO, SRAM_ALIAS_HI);
    assign in_peri  = in_rng(addr, PERI_ALIAS_LO, PERI_ALIAS_HI);
    assign diff     = addr - (in_peri ? PERI_ALIAS_LO : SRAM_ALIAS_LO);
    // Only 20 offset bits survive, so the band stays inside 1 MB.
    assign byte_off = diff[BYTE_OFF_LSB +: BYTE_OFF_W];
    assign bit_num  = diff[BIT_NUM_LSB +: BIT_NUM_W];
    assign band     = (in_peri ? PERI_BAND_BASE : SRAM_BAND_BASE)
                    + {12'h000, byte_off};

    // Byte lanes follow the low address bits, least significant first.
    assign bit_pos  = {band[1:0], bit_num};

    always_comb begin
        tgt_addr = addr;
        // Fetches keep their own address; only data accesses fold.
        if ((in_sram || in_peri) && !fetch) begin
            // The underlying access is aligned to the alias access size.
            case (size)
                SZ_BYTE: tgt_addr = band;
                SZ_HALF: tgt_addr = {band[31:1], 1'b0};
                default: tgt_addr = {band[31:2], 2'b00};
            endcase
        end
    end

    always_comb begin
        if (in_peri && fetch) begin
            kind = BBR_FAULT;
        end else if (in_sram && fetch) begin
            kind = BBR_PASS;
        end else if (in_sram || in_peri) begin
            kind = BBR_ALIAS;
        end else if (is_reserved(addr)) begin
            kind = BBR_FAULT;
        end else begin
            kind = BBR_PASS;
        end
    end

endmodule // bbr_decode

// ===== rtl/bbr_bitlane.sv
// Single-bit insert and extract on a 32-bit data word.
// Combinational; bit position is already lane-adjusted by the caller.
`timescale 1ns/1ps
module bbr_bitlane (
    // Word and target bit
    input  wire logic [31:0] old_word,
    input  wire logic [4:0]  bit_pos,
    input  wire logic        set_val,
    // Results
    output logic [31:0]      new_word,
    output logic             bit_val
);

    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_lane
            // Every other bit is written back exactly as it was read.
            assign new_word[i] = (bit_pos == 5'(i)) ? set_val
                                                    : old_word[i];
        end
    endgenerate

    assign bit_val = old_word[bit_pos];

endmodule // bbr_bitlane

// ===== rtl/bbr_remap.sv
// Bit-band remapper between the core data bus and the memory side.
// Assumes one outstanding request and a memory that answers each
// request with a one-cycle MEM_ACK on the same clock.
`timescale 1ns/1ps

module bbr_remap
    import bbr_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // Request from the core
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic [31:0] REQ_ADDR,
    input  wire logic        REQ_WRITE,
    input  wire logic [1:0]  REQ_SIZE,
    input  wire logic        REQ_FETCH,
    input  wire logic [31:0] REQ_WDATA,
    // Answer to the core
    output logic             RSP_VALID,
    output logic [31:0]      RSP_RDATA,
    output logic             RSP_FAULT,
    // Request to memory
    output logic             MEM_REQ,
    output logic [31:0]      MEM_ADDR,
    output logic             MEM_WRITE,
    output logic [1:0]       MEM_SIZE,
    output logic             MEM_FETCH,
    output logic [31:0]      MEM_WDATA,
    output logic             MEM_LOCK,
    // Answer from memory
    input  wire logic        MEM_ACK,
    input  wire logic [31:0] MEM_RDATA,
    input  wire logic        MEM_ERR
);

    bbr_state_t  state_r;
    bbr_state_t  state_nxt;

    // Decoded view of the incoming request.
    bbr_kind_t   kind;
    logic [31:0] tgt_addr;
    logic [4:0]  bit_pos;

    // Request attributes kept for the alias sequence.
    logic [4:0]  bit_pos_r;
    logic        set_val_r;

    // Bit lane results on the word returned by memory.
    logic [31:0] new_word;
    logic        bit_val;

    logic        take;
    logic        ack_err;

    logic        mem_req_r;
    logic [31:0] mem_addr_r;
    logic        mem_write_r;
    logic [1:0]  mem_size_r;
    logic        mem_fetch_r;
    logic [31:0] mem_wdata_r;
    logic        mem_lock_r;

    logic        rsp_valid_r;
    logic [31:0] rsp_rdata_r;
    logic        rsp_fault_r;

    bbr_decode u_decode (
        .addr     (REQ_ADDR),
        .size     (REQ_SIZE),
        .fetch    (REQ_FETCH),
        .kind     (kind),
        .tgt_addr (tgt_addr),
        .bit_pos  (bit_pos)
    );

    bbr_bitlane u_bitlane (
        .old_word (MEM_RDATA),
        .bit_pos  (bit_pos_r),
        .set_val  (set_val_r),
        .new_word (new_word),
        .bit_val  (bit_val)
    );

    // A new request is taken only while nothing is in flight.
    assign REQ_READY = (state_r == ST_IDLE);
    assign take      = REQ_VALID && REQ_READY;
    assign ack_err   = MEM_ACK && MEM_ERR;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    if (kind == BBR_FAULT) begin
                        state_nxt = ST_IDLE;
                    end else if (kind == BBR_PASS) begin
                        state_nxt = ST_PASS;
                    end else if (REQ_WRITE) begin
                        state_nxt = ST_RMW_RD;
                    end else begin
                        state_nxt = ST_ARD;
                    end
                end
            end
            ST_PASS, ST_ARD, ST_RMW_WR: begin
                if (MEM_ACK) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RMW_RD: begin
                if (MEM_ACK) begin
                    // A failed read never turns into a write.
                    state_nxt = MEM_ERR ? ST_IDLE : ST_RMW_WR;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Target bit and its new value, captured with the request.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bit_pos_r <= 5'h00;
            set_val_r <= 1'b0;
        end else if (take) begin
            bit_pos_r <= bit_pos;
            set_val_r <= REQ_WDATA[0];
        end
    end

    // Memory request: held until acknowledged.  After the read half
    // of an alias write it stays up, now as the write of the new word.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mem_req_r   <= 1'b0;
            mem_addr_r  <= 32'h0000_0000;
            mem_write_r <= 1'b0;
            mem_size_r  <= SZ_WORD;
            mem_fetch_r <= 1'b0;
            mem_wdata_r <= 32'h0000_0000;
        end else if (take && (kind != BBR_FAULT)) begin
            mem_req_r   <= 1'b1;
            mem_addr_r  <= tgt_addr;
            mem_size_r  <= REQ_SIZE;
            mem_fetch_r <= REQ_FETCH;
            if (kind == BBR_ALIAS) begin
                mem_write_r <= 1'b0;
                mem_wdata_r <= 32'h0000_0000;
            end else begin
                mem_write_r <= REQ_WRITE;
                mem_wdata_r <= REQ_WDATA;
            end
        end else if (MEM_ACK && (state_r == ST_RMW_RD) && !MEM_ERR) begin
            mem_write_r <= 1'b1;
            mem_wdata_r <= new_word;
        end else if (MEM_ACK) begin
            mem_req_r   <= 1'b0;
            mem_write_r <= 1'b0;
        end
    end

    // Lock keeps the memory side from interleaving another master
    // between the read and the write back, so the update is atomic.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mem_lock_r <= 1'b0;
        end else if (take && (kind == BBR_ALIAS) && REQ_WRITE) begin
            mem_lock_r <= 1'b1;
        end else if (MEM_ACK && (state_r == ST_RMW_WR)) begin
            mem_lock_r <= 1'b0;
        end else if (ack_err && (state_r == ST_RMW_RD)) begin
            mem_lock_r <= 1'b0;
        end
    end

    // Answer to the core: one-cycle pulse with registered data.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= RDATA_RST;
            rsp_fault_r <= 1'b0;
        end else begin
            rsp_valid_r <= 1'b0;
            rsp_fault_r <= 1'b0;
            if (take && (kind == BBR_FAULT)) begin
                rsp_valid_r <= 1'b1;
                rsp_rdata_r <= RDATA_RST;
                rsp_fault_r <= 1'b1;
            end else if (MEM_ACK) begin
                case (state_r)
                    ST_PASS: begin
                        rsp_valid_r <= 1'b1;
                        rsp_rdata_r <= MEM_RDATA;
                        rsp_fault_r <= MEM_ERR;
                    end
                    ST_ARD: begin
                        rsp_valid_r <= 1'b1;
                        rsp_rdata_r <= {31'h0000_0000, bit_val};
                        rsp_fault_r <= MEM_ERR;
                    end
                    ST_RMW_RD: begin
                        // Only a failed read ends the sequence here.
                        rsp_valid_r <= MEM_ERR;
                        rsp_rdata_r <= RDATA_RST;
                        rsp_fault_r <= MEM_ERR;
                    end
                    ST_RMW_WR: begin
                        rsp_valid_r <= 1'b1;
                        rsp_rdata_r <= RDATA_RST;
                        rsp_fault_r <= MEM_ERR;
                    end
                    default: begin
                        rsp_valid_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign MEM_REQ   = mem_req_r;
    assign MEM_ADDR  = mem_addr_r;
    assign MEM_WRITE = mem_write_r;
    assign MEM_SIZE  = mem_size_r;
    assign MEM_FETCH = mem_fetch_r;
    assign MEM_WDATA = mem_wdata_r;
    assign MEM_LOCK  = mem_lock_r;

    assign RSP_VALID = rsp_valid_r;
    assign RSP_RDATA = rsp_rdata_r;
    assign RSP_FAULT = rsp_fault_r;

endmodule // bbr_remap

// ===== tb/bbr_mem.sv
// Word memory model standing behind the remapper's memory port.
// Assumes one request at a time; answers with a registered one-cycle ack.
`timescale 1ns/1ps
module bbr_mem #(
    parameter logic [31:0] ERR_A = 32'h4000_0100
) (
    input  wire logic        clk, arst_n, req, write, slow,
    input  wire logic [31:0] addr, wdata,
    input  wire logic [1:0]  size,
    output logic             ack, err,
    output logic [31:0]      rdata
);
    logic [31:0] m [logic [29:0]];
    logic [31:0] o, k;
    logic [1:0]  cnt;

    // Outside an answer the data lines toggle, so stale data never looks valid.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
            err <= 1'b0;
            cnt <= 2'h0;
            rdata <= 32'h0000_0000;
        end else if (req && !ack && cnt != (slow ? 2'h3 : 2'h0)) begin
            cnt <= cnt + 2'h1;
            rdata <= ~rdata;
        end else if (req && !ack) begin
            o = m.exists(addr[31:2]) ? m[addr[31:2]] : 32'h0000_0000;
            k = size == 2'h0 ? 32'hFF << {addr[1:0], 3'h0} :
                size == 2'h1 ? 32'hFFFF << {addr[1], 4'h0} : '1;
            cnt <= 2'h0;
            ack <= 1'b1;
            rdata <= o;
            err <= addr[31:2] == ERR_A[31:2];
            if (write && addr[31:2] != ERR_A[31:2])
                m[addr[31:2]] = (o & ~k) | (wdata & k);
        end else begin
            ack <= 1'b0;
            err <= 1'b0;
            rdata <= ~rdata;
        end
    end
endmodule // bbr_mem

// ===== tb/bbr_remap_chk.sv
// Port-level checker for the remapper, bound to every bbr_remap instance.
// Assumes a memory that acks each request once.
`timescale 1ns/1ps
module bbr_remap_chk
    import bbr_pkg::*;
(
    input wire logic        CLK, ARST_N, REQ_VALID, REQ_READY, REQ_WRITE,
    input wire logic        REQ_FETCH, RSP_VALID, RSP_FAULT, MEM_REQ,
    input wire logic        MEM_WRITE, MEM_FETCH, MEM_LOCK, MEM_ACK, MEM_ERR,
    input wire logic [31:0] REQ_ADDR, REQ_WDATA, RSP_RDATA, MEM_ADDR,
    input wire logic [31:0] MEM_WDATA, MEM_RDATA,
    input wire logic [1:0]  REQ_SIZE, MEM_SIZE
);
    logic tk, sa, pa, al_r, w0_r, bit_r;
    logic [4:0] pos_r;
    assign tk = REQ_VALID && REQ_READY;
    assign sa = REQ_ADDR >= SRAM_ALIAS_LO && REQ_ADDR <= SRAM_ALIAS_HI;
    assign pa = REQ_ADDR >= PERI_ALIAS_LO && REQ_ADDR <= PERI_ALIAS_HI;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            al_r <= 1'b0;
            w0_r <= 1'b0;
            pos_r <= 5'h0;
        end else if (tk) begin
            al_r <= (sa || pa) && !REQ_FETCH;
            w0_r <= REQ_WDATA[0];
            pos_r <= REQ_ADDR[6:2];
        end
    end
    always_ff @(posedge CLK) bit_r <= MEM_RDATA[pos_r];

    function automatic logic [31:0] band(input logic [31:0] a,
                                         input logic [1:0] s);
        logic [31:0] b;
        b = {a[31:28] == 4'h4 ? 12'h400 : 12'h200, a[24:5]};
        return s == SZ_WORD ? {b[31:2], 2'h0} :
               s == SZ_HALF ? {b[31:1], 1'h0} : b;
    endfunction

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    AST_MAP: assert property (tk && (sa || pa) && !REQ_FETCH |=> MEM_REQ
        && MEM_ADDR == band($past(REQ_ADDR), $past(REQ_SIZE))
        && MEM_SIZE == $past(REQ_SIZE)) else $error("alias map wrong");
    AST_RMW_RD: assert property (tk && (sa || pa) && !REQ_FETCH && REQ_WRITE
        |=> MEM_LOCK && !MEM_WRITE) else $error("rmw read missing");
    AST_RMW_WR: assert property (MEM_REQ && MEM_ACK && MEM_LOCK && !MEM_WRITE
        && !MEM_ERR |=> MEM_REQ && MEM_WRITE && MEM_LOCK && MEM_WDATA ==
        (w0_r ? $past(MEM_RDATA) | (32'h1 << pos_r)
              : $past(MEM_RDATA) & ~(32'h1 << pos_r))) else $error("rmw bad");
    AST_ARD: assert property (MEM_REQ && MEM_ACK && al_r && !MEM_LOCK
        && !MEM_ERR |=> RSP_VALID && RSP_RDATA == {31'h0, bit_r})
        else $error("alias read data wrong");
    AST_FETCH_P: assert property (tk && pa && REQ_FETCH
        |=> RSP_VALID && RSP_FAULT && !MEM_REQ) else $error("fetch passed");
    AST_FETCH_S: assert property (tk && sa && REQ_FETCH |=> MEM_REQ
        && MEM_FETCH && MEM_ADDR == $past(REQ_ADDR)) else $error("fetch remap");
    AST_RSV: assert property (tk && (REQ_ADDR >= 32'hE010_0000 ||
        (REQ_ADDR >= 32'h4400_0000 && REQ_ADDR < 32'h6000_0000) ||
        (REQ_ADDR >= 32'h2230_0000 && REQ_ADDR < 32'h4000_0000))
        |=> RSP_VALID && RSP_FAULT && !MEM_REQ) else $error("no fault");
    AST_PASS: assert property (tk && (REQ_ADDR < 32'h0004_0000 ||
        (REQ_ADDR >= SRAM_BAND_BASE && REQ_ADDR < 32'h2002_0000) ||
        REQ_ADDR[31:20] == 12'h400) |=> MEM_REQ && !MEM_LOCK
        && MEM_ADDR == $past(REQ_ADDR) && MEM_WDATA == $past(REQ_WDATA)
        && MEM_WRITE == $past(REQ_WRITE)) else $error("pass altered");
    AST_ACK_RSP: assert property (MEM_REQ && MEM_ACK && (MEM_ERR ||
        !(MEM_LOCK && !MEM_WRITE)) |=> RSP_VALID && RSP_FAULT ==
        $past(MEM_ERR)) else $error("answer missing");
endmodule // bbr_remap_chk

// ===== tb/tb_top.sv
// Self-checking bench: drives the core side, memory model on the far side.
// Inputs change on the falling clock edge only.
`timescale 1ns/1ps
module tb_top;
    import bbr_pkg::*;
    logic CLK = 0, ARST_N = 0, REQ_VALID = 0, REQ_WRITE = 0, REQ_FETCH = 0;
    logic slow = 0, f;
    logic [31:0] REQ_ADDR = 0, REQ_WDATA = 0, r;
    logic [1:0]  REQ_SIZE = SZ_WORD, MEM_SIZE;
    logic REQ_READY, RSP_VALID, RSP_FAULT, MEM_REQ, MEM_WRITE, MEM_FETCH;
    logic MEM_LOCK, MEM_ACK, MEM_ERR;
    logic [31:0] RSP_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
    int errors = 0, n_compared = 0;
    logic [7:0] e8 = 8'h90;

    always #10 CLK = ~CLK;

    bbr_remap DUT (
        .CLK(CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE),
        .REQ_SIZE(REQ_SIZE), .REQ_FETCH(REQ_FETCH), .REQ_WDATA(REQ_WDATA),
        .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .RSP_FAULT(RSP_FAULT),
        .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_WRITE(MEM_WRITE),
        .MEM_SIZE(MEM_SIZE), .MEM_FETCH(MEM_FETCH), .MEM_WDATA(MEM_WDATA),
        .MEM_LOCK(MEM_LOCK), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
        .MEM_ERR(MEM_ERR));
    bbr_mem mem (.clk(CLK), .arst_n(ARST_N), .req(MEM_REQ),
        .write(MEM_WRITE), .slow(slow), .addr(MEM_ADDR), .wdata(MEM_WDATA),
        .size(MEM_SIZE), .ack(MEM_ACK), .err(MEM_ERR), .rdata(MEM_RDATA));

    task cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // A missing answer leaves the fault flag unknown, so it cannot match.
    task acc(input logic [31:0] a, input logic w, input logic [1:0] s,
             input logic fe, input logic [31:0] d);
        int i;
        @(negedge CLK);
        {REQ_VALID, REQ_ADDR, REQ_WRITE, REQ_SIZE} = {1'b1, a, w, s};
        {REQ_FETCH, REQ_WDATA} = {fe, d};
        for (i = 0; i < 50 && REQ_READY !== 1'b1; i++) @(negedge CLK);
        @(negedge CLK);
        REQ_VALID = 0;
        for (i = 0; i < 50 && RSP_VALID !== 1'b1; i++) @(negedge CLK);
        r = RSP_VALID === 1'b1 ? RSP_RDATA : 32'hxxxx_xxxx;
        f = RSP_VALID === 1'b1 ? RSP_FAULT : 1'bx;
        if (RSP_VALID !== 1'b1)
            cmp({31'h0, RSP_VALID}, 32'h1);
    endtask

    task t_direct;
        acc(32'h0000_0100, 1, SZ_WORD, 0, 32'hCAFE_0001);
        acc(32'h0000_0100, 0, SZ_WORD, 0, 0);
        cmp(r, 32'hCAFE_0001);
        acc(32'h2000_0000, 1, SZ_WORD, 0, 32'h4433_2211);
        cmp({31'h0, f}, 0);
        acc(32'h2000_0002, 1, SZ_BYTE, 0, 32'h00AA_0000);
        acc(32'h2000_0000, 0, SZ_WORD, 0, 0);
        cmp(r, 32'h44AA_2211);
    endtask

    task t_alias;
        acc(32'h2200_001C, 1, SZ_WORD, 0, 32'hFF);
        cmp(r, 32'h0000_0000);
        acc(32'h2200_0000, 1, SZ_WORD, 0, 32'h0E);
        acc(32'h2200_002C, 1, SZ_BYTE, 0, 32'h1);
        acc(32'h2200_0054, 1, SZ_HALF, 0, 32'h0);
        acc(32'h2000_0000, 0, SZ_WORD, 0, 0);
        cmp(r, 32'h448A_2A90);
        acc(32'h2200_0054, 0, SZ_HALF, 0, 0);
        cmp(r, 32'h0000_0000);
        for (int b = 0; b < 8; b++) begin
            acc(32'h2200_0000 + 4 * b, 0, SZ_WORD, 0, 0);
            cmp(r, {31'h0, e8[b]});
        end
    endtask

    // Slow memory answers stretch every transfer of the read-modify-write.
    task t_peri;
        slow = 1;
        acc(32'h4200_0088, 1, SZ_WORD, 0, 32'h3);
        acc(32'h4000_0004, 0, SZ_WORD, 0, 0);
        cmp(r, 32'h0000_0004);
        acc(32'h43FF_FFFC, 1, SZ_WORD, 0, 32'h1);
        acc(32'h400F_FFFC, 0, SZ_WORD, 0, 0);
        cmp(r, 32'h8000_0000);
        acc(32'h4200_0088, 0, SZ_WORD, 0, 0);
        cmp(r, 32'h0000_0001);
        slow = 0;
    endtask

    task t_fault;
        acc(32'h4200_0000, 0, SZ_WORD, 1, 0);
        cmp({31'h0, f}, 1);
        acc(32'h4400_0000, 0, SZ_WORD, 0, 0);
        cmp({31'h0, f}, 1);
        acc(32'h2230_0000, 1, SZ_WORD, 0, 0);
        cmp({31'h0, f}, 1);
        acc(32'h4200_2000, 1, SZ_WORD, 0, 1);
        cmp({31'h0, f}, 1);
        acc(32'h2200_0000, 0, SZ_WORD, 1, 0);
        cmp({f, r[30:0]}, 0);
    endtask

    task results;
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge CLK);
        @(negedge CLK) ARST_N = 1;
        t_direct;
        t_alias;
        t_peri;
        t_fault;
        results;
    end

    initial begin
        #100000;
        errors++;
        results;
    end
endmodule // tb_top

bind bbr_remap bbr_remap_chk chk (
    .CLK(CLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_FETCH(REQ_FETCH),
    .RSP_VALID(RSP_VALID), .RSP_FAULT(RSP_FAULT), .MEM_REQ(MEM_REQ),
    .MEM_WRITE(MEM_WRITE), .MEM_FETCH(MEM_FETCH), .MEM_LOCK(MEM_LOCK),
    .MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .REQ_SIZE(REQ_SIZE),
    .MEM_SIZE(MEM_SIZE));
